// File: inc/pts_pkg.sv
// Shared constants and bus carriers for the period timer block.
// Assumes an AXI4-Lite master with 32-bit data and 12-bit addresses.
`default_nettype none

package pts_pkg;

  // ************************************************************
  // Bus carriers
  // ************************************************************
  localparam int AXI_AW = 12;

  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } pts_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pts_axi_rsp_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Register map: index, byte address is four times the index
  // ************************************************************
  localparam int         IDX_LSB       = 2;
  localparam int         IDX_W         = 8;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_COUNTER   = 8'h11;
  localparam logic [7:0] IDX_CONTROL   = 8'h12;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h8C;
  localparam logic [7:0] IDX_LIMIT     = 8'h92;

  // Reset values and field layout
  localparam logic [7:0] RST_COUNTER  = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_LIMIT    = 8'hFF;
  localparam logic [7:0] CTL_WR_MASK  = 8'h7F;
  localparam int         CTL_PRE_LO   = 0;
  localparam int         CTL_PRE_HI   = 1;
  localparam int         CTL_RUN      = 2;
  localparam int         CTL_POST_LO  = 3;
  localparam int         CTL_POST_HI  = 6;
  localparam int         CTL_UNUSED   = 7;
  localparam int         IRQ_MATCH    = 1;

  // ************************************************************
  // Clocking: internal clock divided by four, then prescaled
  // ************************************************************
  localparam int INSTR_DIV = 4;
  localparam int PRE_CNT_W = 6;
  localparam logic [PRE_CNT_W-1:0] PRE_TERM_1  = 6'(INSTR_DIV * 1 - 1);
  localparam logic [PRE_CNT_W-1:0] PRE_TERM_4  = 6'(INSTR_DIV * 4 - 1);
  localparam logic [PRE_CNT_W-1:0] PRE_TERM_16 = 6'(INSTR_DIV * 16 - 1);
  localparam int POST_CNT_W = 4;

endpackage

`default_nettype wire

// File: design/pts_prescaler.sv
// Prescaler: one tick per (limit+1) system clocks while running.
// Assumes limit only changes together with a clear pulse.
`default_nettype none

module pts_prescaler #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Control
  input  wire logic         clear,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  // Tick out
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] count;
  } pts_pre_state_t;

  pts_pre_state_t s;
  pts_pre_state_t next_s;

  // Terminal count of 63 needs six bits
  if (W < 6) begin : g_chk
    $error("pts_prescaler: W too small");
  end

  // Clear outranks the tick so a write restarts a full period
  assign tick = run && !clear && (s.count == limit);

  // Next state
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.count = '0;
    end else if (run) begin
      next_s.count = (s.count == limit) ? '0 : s.count + 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// File: design/pts_postscaler.sv
// Postscaler: counts period matches, fires on the selected count.
// Assumes match is a one-cycle pulse from the period counter.
`default_nettype none

module pts_postscaler #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Control
  input  wire logic         clear,
  input  wire logic         match,
  input  wire logic [W-1:0] select,
  // Event out
  output logic              fire
);

  typedef struct packed {
    logic [W-1:0] count;
  } pts_post_state_t;

  pts_post_state_t s;
  pts_post_state_t next_s;

  // Ratio field is four bits wide
  if (W < 4) begin : g_chk
    $error("pts_postscaler: W too small");
  end

  // Fires on the match that equals the select value
  assign fire = match && !clear && (s.count == select);

  // Next state: restart from zero after firing
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.count = '0;
    end else if (match) begin
      next_s.count = (s.count == select) ? '0 : s.count + 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// File: design/pts_timer_top.sv
// Period timer with prescaler, postscaler and AXI4-Lite registers.
// Assumes a single clock domain; registers sit in data bits 7:0.
//
// Function
// R1: Counter counts up from zero, wraps to zero after equalling limit.
// R2: Counter clock is internal clock divided by four, then prescaled.
// R3: Prescale code 00 divides by 1, 01 by 4, 1x by 16.
// R4: Counter is software read/write and cleared by reset.
// R5: Limit register is read/write and resets to all ones.
// R6: Matches pass a 4-bit postscaler that sets the interrupt flag.
// R7: Postscale field gives ratio of one plus its value.
// R8: Run bit gates the counter; cleared it holds its value.
// R9: Counter write, control write or reset clears both scaler counts.
// R10: A control write leaves the counter value unchanged.
// R11: Control bit 7 is unimplemented and reads zero.
// R12: Period match is exported as the shared PWM time-base.
// R13: Interrupt flag stays set until software writes it to zero.
// R14: Postscaler counts matches from zero, fires on select, restarts.
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none

module pts_timer_top #(
  parameter int PRE_W  = 6,
  parameter int POST_W = 4
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // Register bus
  input  wire pts_pkg::pts_axi_req_t axiReq,
  output pts_pkg::pts_axi_rsp_t      axiRsp,
  // Interrupt and PWM time-base
  output logic                       irq,
  output logic                       pwmTimeBase,
  output logic [7:0]                 pwmCount
);
  import pts_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]        counter;
    logic [7:0]        limit;
    logic [7:0]        control;
    logic              flag;
    logic              enable;
    logic              irq;
    logic              match;
    logic              awHeld;
    logic [AXI_AW-1:0] awAddr;
    logic              wHeld;
    logic [7:0]        wData;
    logic              wStrb0;
    pts_axi_rsp_t      rsp;
  } pts_top_state_t;

  pts_top_state_t s;
  pts_top_state_t next_s;

  if (PRE_W != PRE_CNT_W || POST_W != POST_CNT_W) begin : g_chk
    $error("pts_timer_top: scaler widths unsupported");
  end

  logic                  doWrite;
  logic [IDX_W-1:0]      wrIdx;
  logic                  wrInMap;
  logic                  wrLane;
  logic                  wrCounter;
  logic                  wrControl;
  logic                  wrFlags;
  logic                  wrEnable;
  logic                  wrLimit;
  logic                  wrKnown;
  logic                  scalerClear;
  logic [PRE_CNT_W-1:0]  preLimit;
  logic                  preTick;
  logic                  postFire;
  logic                  matchNow;
  logic                  arTake;
  logic                  rdOk;
  logic [7:0]            rdData;

  // ************************************************************
  // Write decode, one write per completed address/data pair
  // ************************************************************
  assign doWrite   = s.awHeld && s.wHeld && !s.rsp.bvalid;
  assign wrIdx     = s.awAddr[IDX_LSB +: IDX_W];
  assign wrInMap   = s.awAddr[AXI_AW-1:IDX_LSB+IDX_W] == '0;
  assign wrLane    = doWrite && wrInMap && s.wStrb0;
  assign wrCounter = wrLane && (wrIdx == IDX_COUNTER);
  assign wrControl = wrLane && (wrIdx == IDX_CONTROL);
  assign wrFlags   = wrLane && (wrIdx == IDX_IRQ_FLAGS);
  assign wrEnable  = wrLane && (wrIdx == IDX_IRQ_EN);
  assign wrLimit   = wrLane && (wrIdx == IDX_LIMIT);
  assign wrKnown   = wrInMap && (wrIdx == IDX_COUNTER ||
                     wrIdx == IDX_CONTROL || wrIdx == IDX_IRQ_FLAGS ||
                     wrIdx == IDX_IRQ_EN || wrIdx == IDX_LIMIT);

  // Scalers restart on counter or control write
  assign scalerClear = wrCounter || wrControl; // R9

  // ************************************************************
  // Prescaler and postscaler
  // ************************************************************
  // Quarter-rate clock folded into the prescaler terminal count
  always_comb begin
    if (s.control[CTL_PRE_HI]) begin
      preLimit = PRE_TERM_16; // R3
    end else if (s.control[CTL_PRE_LO]) begin
      preLimit = PRE_TERM_4; // R3
    end else begin
      preLimit = PRE_TERM_1; // R2
    end
  end

  pts_prescaler #(
    .W (PRE_W)
  ) uPre (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clear   (scalerClear),
    .run     (s.control[CTL_RUN]),
    .limit   (preLimit),
    .tick    (preTick)
  );

  // Wrap event of the period counter
  assign matchNow = preTick && (s.counter == s.limit); // R1

  pts_postscaler #(
    .W (POST_W)
  ) uPost (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clear   (scalerClear),
    .match   (matchNow),
    .select  (s.control[CTL_POST_HI:CTL_POST_LO]), // R7
    .fire    (postFire)
  );

  // ************************************************************
  // Read mux; unmapped addresses answer SLVERR, with zero data unless the index bits match a register
  // ************************************************************
  always_comb begin
    rdOk   = axiReq.araddr[AXI_AW-1:IDX_LSB+IDX_W] == '0;
    rdData = 8'h00;
    unique case (axiReq.araddr[IDX_LSB +: IDX_W])
      IDX_COUNTER:   rdData = s.counter;
      IDX_CONTROL:   rdData = s.control & CTL_WR_MASK; // R11
      IDX_LIMIT:     rdData = s.limit;
      IDX_IRQ_FLAGS: rdData = 8'(s.flag) << IRQ_MATCH;
      IDX_IRQ_EN:    rdData = 8'(s.enable) << IRQ_MATCH;
      default:       rdOk   = 1'b0;
    endcase
  end

  assign arTake = axiReq.arvalid && s.rsp.arready;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s       = s;
    next_s.match = 1'b0;
    // Counter advance; a tick never coincides with a counter write
    if (preTick) begin // R8
      if (matchNow) begin
        next_s.counter = 8'h00; // R1
        next_s.match   = 1'b1; // R12
      end else begin
        next_s.counter = s.counter + 8'h01; // R1
      end
    end
    // Write channel capture, either order
    if (axiReq.awvalid && s.rsp.awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s.rsp.wready) begin
      next_s.wHeld  = 1'b1;
      next_s.wData  = axiReq.wdata[7:0];
      next_s.wStrb0 = axiReq.wstrb[0];
    end
    if (doWrite) begin
      next_s.awHeld     = 1'b0;
      next_s.wHeld      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = wrKnown ? RESP_OKAY : RESP_SLVERR;
    end
    if (wrCounter) begin
      next_s.counter = s.wData; // R4
    end
    // Control write keeps the counter value as it is
    if (wrControl) begin
      next_s.control = s.wData & CTL_WR_MASK; // R10 R11
    end
    if (wrLimit) begin
      next_s.limit = s.wData; // R5
    end
    if (wrEnable) begin
      next_s.enable = s.wData[IRQ_MATCH];
    end
    if (wrFlags) begin
      next_s.flag = s.wData[IRQ_MATCH]; // R13
    end
    // Hardware set wins over a clearing write in the same cycle
    if (postFire) begin
      next_s.flag = 1'b1; // R6 R14
    end
    next_s.irq = next_s.flag && next_s.enable;
    if (s.rsp.bvalid && axiReq.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    // Read channel
    if (arTake) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata  = 32'(rdData);
      next_s.rsp.rresp  = rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rsp.rvalid && axiReq.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    // One write and one read outstanding at most
    next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.wHeld && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  // State register; reset restores every documented default
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s               <= '0;
      s.counter       <= RST_COUNTER; // R4
      s.control       <= RST_CONTROL;
      s.limit         <= RST_LIMIT; // R5
      s.rsp.awready   <= 1'b1;
      s.rsp.wready    <= 1'b1;
      s.rsp.arready   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign axiRsp      = s.rsp;
  assign irq         = s.irq;
  assign pwmTimeBase = s.match; // R12
  assign pwmCount    = s.counter;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_wrap;
    matchNow |=> s.counter == 8'h00 && pwmTimeBase;
  endproperty
  a_wrap: assert property (p_wrap) // R1
    else $error("counter did not wrap on match");

  property p_div1_gap;
    preTick && s.control[CTL_PRE_HI:CTL_PRE_LO] == 2'h0
      |=> (!preTick) [*3] ##1 (preTick || scalerClear
      || $past(scalerClear) || $past(scalerClear, 2)
      || $past(scalerClear, 3) || !s.control[CTL_RUN]);
  endproperty
  a_div1_gap: assert property (p_div1_gap) // R2
    else $error("divide-by-1 tick spacing not four");

  property p_div16_gap;
    preTick && s.control[CTL_PRE_HI]
      |=> (!preTick || !s.control[CTL_PRE_HI]) [*8];
  endproperty
  a_div16_gap: assert property (p_div16_gap) // R3
    else $error("divide-by-16 tick came early");

  property p_counter_write;
    wrCounter |=> s.counter == $past(s.wData) && !preTick;
  endproperty
  a_counter_write: assert property (p_counter_write) // R4
    else $error("counter write not stored");

  property p_limit_write;
    wrLimit |=> s.limit == $past(s.wData);
  endproperty
  a_limit_write: assert property (p_limit_write) // R5
    else $error("limit write not stored");

  property p_flag_set;
    postFire |=> s.flag ##1 irq == (s.flag && s.enable);
  endproperty
  a_flag_set: assert property (p_flag_set) // R6
    else $error("postscaled match did not set flag");

  property p_run_hold;
    !s.control[CTL_RUN] && !wrCounter |=> $stable(s.counter);
  endproperty
  a_run_hold: assert property (p_run_hold) // R8
    else $error("stopped counter moved");

  property p_scaler_clear;
    scalerClear |=> (!preTick) [*3];
  endproperty
  a_scaler_clear: assert property (p_scaler_clear) // R9
    else $error("prescaler not restarted by write");

  property p_ctl_keeps_count;
    wrControl |=> s.counter == $past(s.counter);
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count) // R10
    else $error("control write changed counter");

  property p_bit7_zero;
    arTake |=> !axiRsp.rdata[CTL_UNUSED] || !$past(rdOk)
      || $past(axiReq.araddr[IDX_LSB +: IDX_W]) != IDX_CONTROL;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) // R11
    else $error("control bit 7 read as one");

  property p_flag_sticky;
    s.flag && !(wrFlags && !s.wData[IRQ_MATCH]) |=> s.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R13
    else $error("flag dropped without software clear");

  property p_post_1to1;
    matchNow && !scalerClear
      && s.control[CTL_POST_HI:CTL_POST_LO] == 4'h0 |-> postFire;
  endproperty
  a_post_1to1: assert property (p_post_1to1) // R7 R14
    else $error("1:1 postscale did not fire");

  c_wrap: cover property (matchNow);
  c_fire: cover property (postFire && s.control[CTL_POST_HI]);
  c_irq: cover property (irq);
  c_slverr: cover property (axiRsp.rvalid
    && axiRsp.rresp == RESP_SLVERR);

endmodule

`default_nettype wire

// File: tb/test_pts_timer_top.sv
// Self-checking bench for the period timer: AXI4-Lite register tests,
// prescale timing, wrap time-base, postscaler interrupt and scaler clears.
// Assumes the package from inc/ and the design from design/ are compiled.
`default_nettype none

module test_pts_timer_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pts_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic         sys_clk = 1'b0;
  logic         arst_n;
  pts_axi_req_t axiReq;
  pts_axi_rsp_t axiRsp;
  logic         irq;
  logic         pwmTimeBase;
  logic [7:0]   pwmCount;
  int           bad_count;
  int           num_checks;
  int           preDiv[4] = '{1, 4, 16, 16};
  int           postSel[4] = '{0, 1, 2, 15};
  int           limits[3] = '{0, 3, 9};

  pts_timer_top #(
    .PRE_W  (6),
    .POST_W (4)
  ) pts_timer_top_inst (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .axiReq      (axiReq),
    .axiRsp      (axiRsp),
    .irq         (irq),
    .pwmTimeBase (pwmTimeBase),
    .pwmCount    (pwmCount)
  );

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Measured cycle counts, checked against a window
  task automatic chk_rng(input string what, input int lo, input int hi,
                         input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Each channel released at the edge that takes it; bready held to bvalid
  task automatic bus_wr(input logic [11:0] adr, input logic [31:0] dat,
                        output logic [1:0] rsp);
    int k;
    rsp = 2'h3;
    @(posedge sys_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= adr;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= dat;
    axiReq.wstrb   <= 4'hF;
    axiReq.bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge sys_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid === 1'b1) begin
        rsp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic bus_rd(input logic [11:0] adr, output logic [31:0] dat,
                        output logic [1:0] rsp);
    int k;
    rsp = 2'h3;
    dat = 32'hDEAD_BEEF;
    @(posedge sys_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= adr;
    axiReq.rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge sys_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid === 1'b1) begin
        dat = axiRsp.rdata;
        rsp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    logic [1:0] r;
    bus_wr(ba(idx), {24'h0, dat}, r);
    chk("bresp", RESP_OKAY, r);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(ba(idx), d, r);
    chk(what, exp, d);
    chk("rresp", RESP_OKAY, r);
  endtask

  // Cycles between two events: count changes (sel 0) or time-base pulses
  task automatic interval(input int sel, output int n);
    logic [7:0] pc;
    int         k;
    int         ev;
    bit         hit;
    n  = 0;
    ev = 0;
    pc = pwmCount;
    for (k = 0; k < 4000 && ev < 2; k++) begin
      @(posedge sys_clk);
      hit = sel ? (pwmTimeBase === 1'b1) : (pwmCount !== pc);
      pc  = pwmCount;
      if (ev == 1) n++;
      if (hit) ev++;
    end
  endtask

  // Cycles until irq is seen high, or until the count changes
  task automatic wait_for(input int sel, output int n);
    logic [7:0] pc;
    pc = pwmCount;
    for (n = 0; n < 4000; n++) begin
      @(posedge sys_clk);
      if (sel ? (pwmCount !== pc) : (irq === 1'b1)) break;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  // Main sequence: reset, then register, timing and interrupt tests
  initial begin
    int          n;
    int          t0;
    logic [31:0] d;
    logic [1:0]  r;
    axiReq     = '0;
    arst_n     = 1'b0;
    bad_count  = 0;
    num_checks = 0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;

    rd_chk("counter", IDX_COUNTER, 32'h0000_0000);
    rd_chk("control", IDX_CONTROL, 32'h0000_0000);
    rd_chk("limit", IDX_LIMIT, 32'h0000_00FF);
    rd_chk("flags", IDX_IRQ_FLAGS, 32'h0000_0000);
    rd_chk("enables", IDX_IRQ_EN, 32'h0000_0000);
    bus_rd(12'h400, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0000_0000, d);
    bus_wr(ba(8'h00), 32'h0000_00FF, r);
    chk("unmapped bresp", RESP_SLVERR, r);
    wr(IDX_LIMIT, 8'h5A);
    rd_chk("limit", IDX_LIMIT, 32'h0000_005A);
    wr(IDX_CONTROL, 8'hFF);
    rd_chk("control", IDX_CONTROL, 32'h0000_007F);
    wr(IDX_CONTROL, 8'h00);
    $display("test registers done");

    // Tick spacing for every prescale code, no wrap in view
    wr(IDX_LIMIT, 8'hFF);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CONTROL, 8'(4 + c));
      interval(0, n);
      chk_rng("tick gap", INSTR_DIV * preDiv[c],
              INSTR_DIV * preDiv[c], n);
    end
    $display("test prescale done");

    // Period of the time-base, including the limit of zero
    foreach (limits[i]) begin
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_LIMIT, 8'(limits[i]));
      wr(IDX_COUNTER, 8'h00);
      wr(IDX_CONTROL, 8'h04);
      interval(1, n);
      chk_rng("period", (limits[i] + 1) * INSTR_DIV,
              (limits[i] + 1) * INSTR_DIV, n);
    end
    $display("test wrap done");

    // Postscale ratios: delay difference is sel matches of 16 clocks
    wr(IDX_LIMIT, 8'h03);
    wr(IDX_IRQ_EN, 8'h02);
    t0 = 0;
    foreach (postSel[i]) begin
      wr(IDX_CONTROL, 8'(postSel[i] << 3));
      wr(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_COUNTER, 8'h00);
      wr(IDX_CONTROL, 8'((postSel[i] << 3) + 4));
      wait_for(0, n);
      if (i == 0) t0 = n;
      // Flag rises at the fourth tick edge; seen one edge later by the bench
      if (i == 0) chk_rng("first irq", 4 * INSTR_DIV - 1,
                          4 * INSTR_DIV - 1, n);
      else chk_rng("irq delay", postSel[i] * 4 * INSTR_DIV,
                   postSel[i] * 4 * INSTR_DIV, n - t0);
    end
    wr(IDX_CONTROL, 8'h04);
    repeat (50) @(posedge sys_clk);
    rd_chk("flags", IDX_IRQ_FLAGS, 32'h0000_0002);
    chk("irq", 1'b1, irq);
    wr(IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("masked irq", 1'b0, irq);
    rd_chk("flags", IDX_IRQ_FLAGS, 32'h0000_0002);
    wr(IDX_IRQ_EN, 8'h02);
    repeat (2) @(posedge sys_clk);
    chk("irq", 1'b1, irq);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("cleared irq", 1'b0, irq);
    rd_chk("flags", IDX_IRQ_FLAGS, 32'h0000_0000);
    $display("test postscale done");

    // Control write mid-count restarts the prescaler, keeps the count
    wr(IDX_LIMIT, 8'hFF);
    wr(IDX_CONTROL, 8'h06);
    wr(IDX_COUNTER, 8'h50);
    repeat (40) @(posedge sys_clk);
    wr(IDX_CONTROL, 8'h06);
    wait_for(1, n);
    chk_rng("tick after control write", 60, 66, n);
    rd_chk("counter", IDX_COUNTER, 32'h0000_0051);
    wr(IDX_CONTROL, 8'h02);
    repeat (200) @(posedge sys_clk);
    rd_chk("stopped counter", IDX_COUNTER, 32'h0000_0051);
    $display("test scaler clear done");
    finish_test();
  end

  // Watchdog: the tests need under two thousand cycles
  initial begin
    repeat (50000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] watchdog expected end seen timeout");
    finish_test();
  end

endmodule

`default_nettype wire
